//--- hdl/eld_defines.svh
`ifndef ELD_DEFINES_SVH
`define ELD_DEFINES_SVH

// ==========================================================
// register offsets
`define ELD_ADDR_LOSS_CFG 3'h0
`define ELD_ADDR_LOSS_STATUS 3'h1
`define ELD_ADDR_IRQ_STATUS 3'h2
`define ELD_ADDR_IRQ_MASK 3'h3
`define ELD_ADDR_EDGE_SEL 3'h4
`define ELD_ADDR_RX_CFG 3'h5
`define ELD_ADDR_CLOCK_GEN 3'h6
`define ELD_ADDR_TX_CFG 3'h7

// ==========================================================
// field positions
`define ELD_BIT_LINE 0
`define ELD_BIT_SYSTEM 1
`define ELD_BIT_TX 2
`define ELD_BIT_LS_EDGE 1
`define ELD_BIT_TX_EDGE 2
`define ELD_BIT_CRITERIA 7
`define ELD_FLD_LINE_THR_HI 6
`define ELD_FLD_LINE_THR_LO 4
`define ELD_FLD_TX_THR_HI 3
`define ELD_FLD_TX_THR_LO 2
`define ELD_FLD_TX_PER_HI 1
`define ELD_FLD_TX_PER_LO 0
`define ELD_BIT_RX_CLK_HIGH 7
`define ELD_BIT_IND_CLK_EN 3
`define ELD_BIT_IND_CLK_INV 2
`define ELD_BIT_TX_OE 6
`define ELD_FLD_MODE_HI 1
`define ELD_FLD_MODE_LO 0

// ==========================================================
// reset values
`define ELD_RST_LOSS_CFG 8'h00
`define ELD_RST_IRQ_MASK 8'h07
`define ELD_RST_EDGE_SEL 8'h00
`define ELD_RST_RX_CFG 8'h00
`define ELD_RST_CLOCK_GEN 8'h00
`define ELD_RST_TX_CFG 8'h00

// ==========================================================
// counts and timing
`define ELD_NUM_CH 22
`define ELD_DECL_SHORT 32
`define ELD_DECL_LONG 2048
`define ELD_CLR_LEN 32
`define ELD_CLR_MIN_MARKS 4
`define ELD_MAX_ZERO_RUN 16
`define ELD_SYS_CLK_KHZ 200000
`define ELD_REF_CLK_KHZ 2048
`define ELD_REF_HALF_CYC (`ELD_SYS_CLK_KHZ / (2 * `ELD_REF_CLK_KHZ))
`define ELD_TX_PERIOD_0 32
`define ELD_TX_PERIOD_1 64
`define ELD_TX_PERIOD_2 128
`define ELD_TX_PERIOD_3 256

`endif

//--- hdl/eld_pkg.sv
`default_nettype none
package eld_pkg;
    typedef enum logic [1:0] {
        ELD_RX_SR_NRZ,
        ELD_RX_DR_NRZ,
        ELD_RX_DR_RZ,
        ELD_RX_DR_SLICED
    } eld_rx_mode_e;

    typedef enum logic [1:0] {
        ELD_TX_SR_NRZ,
        ELD_TX_DR_NRZ,
        ELD_TX_DR_RZ,
        ELD_TX_OTHER
    } eld_tx_mode_e;

    typedef enum logic [1:0] {
        ELD_ST_MONITOR,
        ELD_ST_LOST_IDLE,
        ELD_ST_LOST_WINDOW
    } eld_det_state_e;
endpackage
`default_nettype wire

//--- hdl/eld_det_if.sv
`timescale 1ns/1ps
`default_nettype none
interface eld_det_if;
    logic enable;
    logic criteria;
    logic bit_en;
    logic mark;
    logic amp_ok;
    logic loss;
    modport det (input enable, input criteria, input bit_en, input mark, input amp_ok,
                 output loss);
    modport user (output enable, output criteria, output bit_en, output mark, output amp_ok,
                  input loss);
endinterface
`default_nettype wire

//--- hdl/eld_loss_det.sv
`timescale 1ns/1ps
`default_nettype none
`include "eld_defines.svh"
module eld_loss_det #(
    parameter int DECL_SHORT = `ELD_DECL_SHORT,
    parameter int DECL_LONG = `ELD_DECL_LONG,
    parameter int CLR_LEN = `ELD_CLR_LEN,
    parameter int MIN_MARKS = `ELD_CLR_MIN_MARKS,
    parameter int MAX_ZRUN = `ELD_MAX_ZERO_RUN
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    eld_det_if.det det
);
    localparam logic [11:0] LIM_SHORT = 12'(DECL_SHORT - 1);
    localparam logic [11:0] LIM_LONG = 12'(DECL_LONG - 1);
    localparam logic [5:0] LIM_WIN = 6'(CLR_LEN - 1);
    localparam logic [5:0] LIM_MARKS = 6'(MIN_MARKS);
    localparam logic [4:0] LIM_RUN = 5'(MAX_ZRUN - 1);

    eld_pkg::eld_det_state_e state, next_state;
    logic [11:0] zero_cnt, next_zero_cnt;
    logic [5:0] win_cnt, next_win_cnt;
    logic [5:0] mark_cnt, next_mark_cnt;
    logic [4:0] run_cnt, next_run_cnt;
    logic valid;
    logic [11:0] decl_lim;

    assign det.loss = (state != eld_pkg::ELD_ST_MONITOR);

    // ==========================================================
    // declare and clear sequencing
    always_comb begin
        next_state = state;
        next_zero_cnt = zero_cnt;
        next_win_cnt = win_cnt;
        next_mark_cnt = mark_cnt;
        next_run_cnt = run_cnt;
        valid = det.mark & det.amp_ok;
        decl_lim = det.criteria ? LIM_LONG : LIM_SHORT;
        if (!det.enable) begin
            next_state = eld_pkg::ELD_ST_MONITOR;
            next_zero_cnt = 12'h000;
        end else if (det.bit_en) begin
            unique case (state)
                eld_pkg::ELD_ST_MONITOR: begin
                    if (det.mark) begin
                        next_zero_cnt = 12'h000;
                    end else if (zero_cnt >= decl_lim) begin
                        next_state = eld_pkg::ELD_ST_LOST_IDLE;
                        next_zero_cnt = 12'h000;
                    end else begin
                        next_zero_cnt = zero_cnt + 12'h001;
                    end
                end
                eld_pkg::ELD_ST_LOST_IDLE: begin
                    if (valid) begin
                        next_state = eld_pkg::ELD_ST_LOST_WINDOW;
                        next_win_cnt = 6'h01;
                        next_mark_cnt = 6'h01;
                        next_run_cnt = 5'h00;
                    end
                end
                eld_pkg::ELD_ST_LOST_WINDOW: begin
                    if (det.mark && !det.amp_ok) begin
                        next_state = eld_pkg::ELD_ST_LOST_IDLE;
                    end else if (!det.mark && run_cnt == LIM_RUN) begin
                        next_state = eld_pkg::ELD_ST_LOST_IDLE;
                    end else begin
                        next_win_cnt = win_cnt + 6'h01;
                        next_mark_cnt = mark_cnt + {5'h00, valid};
                        next_run_cnt = valid ? 5'h00 : run_cnt + 5'h01;
                        if (win_cnt == LIM_WIN) begin
                            if (next_mark_cnt >= LIM_MARKS) begin
                                next_state = eld_pkg::ELD_ST_MONITOR;
                                next_zero_cnt = 12'h000;
                            end else begin
                                next_state = eld_pkg::ELD_ST_LOST_IDLE;
                            end
                        end
                    end
                end
                default: begin
                    next_state = eld_pkg::ELD_ST_MONITOR;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= eld_pkg::ELD_ST_MONITOR;
            zero_cnt <= 12'h000;
            win_cnt <= 6'h00;
            mark_cnt <= 6'h00;
            run_cnt <= 5'h00;
        end else begin
            state <= next_state;
            zero_cnt <= next_zero_cnt;
            win_cnt <= next_win_cnt;
            mark_cnt <= next_mark_cnt;
            run_cnt <= next_run_cnt;
        end
    end
endmodule
`default_nettype wire

//--- hdl/eld_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "eld_defines.svh"
// Operation
// - line loss after N weak intervals
// - line clear after 32-interval window with at least 4 marks
// - line threshold field, clear adds 250 mV
// - criteria bit selects N for both
// - line status bit 0, edge-selected irq
// - irq low when unmasked status set
// - serial pin scans 22 channels, marker slot
// - serial pins change on indication rise
// - disabled indication clock tristates pins
// - rx data low unless sliced mode
// - rx clock high or reference clock
// - overriding functions own rx outputs
// - system detection only dual-rail modes
// - system loss after N zero intervals
// - system clear after 32-interval window with at least 4 marks
// - system status bit 1, edge-selected irq
// - tx loss after weak period, fast clear
// - tx status bit 2, own edge select
// - shared line, disabled system detector reports no loss
// - loss flags exported to counters, muxes
module eld_top #(
    parameter int NUM_CH = `ELD_NUM_CH,
    parameter int REF_HALF = `ELD_REF_HALF_CYC,
    parameter int TX_PERIOD_0 = `ELD_TX_PERIOD_0,
    parameter int TX_PERIOD_1 = `ELD_TX_PERIOD_1,
    parameter int TX_PERIOD_2 = `ELD_TX_PERIOD_2,
    parameter int TX_PERIOD_3 = `ELD_TX_PERIOD_3
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic line_bit_en_i,
    input wire logic line_mark_i,
    input wire logic line_above_clear_i,
    input wire logic sys_bit_en_i,
    input wire logic sys_mark_i,
    input wire logic tx_bit_en_i,
    input wire logic tx_pulse_ok_i,
    input wire logic [NUM_CH-1:1] other_line_loss_i,
    input wire logic rx_data_i,
    input wire logic rx_data_pos_i,
    input wire logic rx_data_neg_i,
    input wire logic rx_clock_i,
    input wire logic rx_override_i,
    output logic [2:0] line_amplitude_threshold_o,
    output logic [1:0] tx_amplitude_threshold_o,
    output logic tx_output_enable_o,
    output logic line_signal_loss_o,
    output logic system_signal_loss_o,
    output logic transmit_signal_loss_o,
    output logic rx_multiplex_indicator_o,
    output logic tx_multiplex_indicator_o,
    output logic irq_b_o,
    output logic indication_clock_out_o,
    output logic indication_clock_oe_o,
    output logic serial_loss_o,
    output logic serial_loss_oe_o,
    output logic serial_loss_marker_pin_o,
    output logic serial_loss_marker_oe_o,
    output logic rx_data_out_o,
    output logic rx_data_pos_out_o,
    output logic rx_data_neg_out_o,
    output logic rx_clock_out_o
);
    localparam logic [5:0] REF_LIM = 6'(REF_HALF - 1);
    localparam logic [4:0] SLOT_LIM = 5'(NUM_CH - 1);

    function automatic logic [11:0] tx_period_lim(input logic [1:0] sel);
        logic [11:0] lim;
        lim = 12'(TX_PERIOD_0 - 1);
        unique case (sel)
            2'h0: lim = 12'(TX_PERIOD_0 - 1);
            2'h1: lim = 12'(TX_PERIOD_1 - 1);
            2'h2: lim = 12'(TX_PERIOD_2 - 1);
            2'h3: lim = 12'(TX_PERIOD_3 - 1);
        endcase
        return lim;
    endfunction

    // ==========================================================
    // register file
    logic [7:0] loss_cfg_reg, next_loss_cfg_reg;
    logic [7:0] irq_mask_reg, next_irq_mask_reg;
    logic [7:0] irq_edge_select_reg, next_irq_edge_select_reg;
    logic [7:0] rx_config_reg, next_rx_config_reg;
    logic [7:0] clock_gen_reg, next_clock_gen_reg;
    logic [7:0] tx_config_reg, next_tx_config_reg;
    logic [7:0] next_reg_rdata;
    logic [2:0] loss_status_reg;
    logic [2:0] irq_status_reg, next_irq_status_reg;

    always_comb begin
        next_loss_cfg_reg = loss_cfg_reg;
        next_irq_mask_reg = irq_mask_reg;
        next_irq_edge_select_reg = irq_edge_select_reg;
        next_rx_config_reg = rx_config_reg;
        next_clock_gen_reg = clock_gen_reg;
        next_tx_config_reg = tx_config_reg;
        next_reg_rdata = 8'h00;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                `ELD_ADDR_LOSS_CFG: next_loss_cfg_reg = reg_wdata_i;
                `ELD_ADDR_IRQ_MASK: next_irq_mask_reg = reg_wdata_i & 8'h07;
                `ELD_ADDR_EDGE_SEL: next_irq_edge_select_reg = reg_wdata_i & 8'h06;
                `ELD_ADDR_RX_CFG: next_rx_config_reg = reg_wdata_i & 8'h83;
                `ELD_ADDR_CLOCK_GEN: next_clock_gen_reg = reg_wdata_i & 8'h0c;
                `ELD_ADDR_TX_CFG: next_tx_config_reg = reg_wdata_i & 8'h43;
                default: begin
                end
            endcase
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `ELD_ADDR_LOSS_CFG: next_reg_rdata = loss_cfg_reg;
                `ELD_ADDR_LOSS_STATUS: next_reg_rdata = {5'h00, loss_status_reg};
                `ELD_ADDR_IRQ_STATUS: next_reg_rdata = {5'h00, irq_status_reg};
                `ELD_ADDR_IRQ_MASK: next_reg_rdata = irq_mask_reg;
                `ELD_ADDR_EDGE_SEL: next_reg_rdata = irq_edge_select_reg;
                `ELD_ADDR_RX_CFG: next_reg_rdata = rx_config_reg;
                `ELD_ADDR_CLOCK_GEN: next_reg_rdata = clock_gen_reg;
                `ELD_ADDR_TX_CFG: next_reg_rdata = tx_config_reg;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            loss_cfg_reg <= `ELD_RST_LOSS_CFG;
            irq_mask_reg <= `ELD_RST_IRQ_MASK;
            irq_edge_select_reg <= `ELD_RST_EDGE_SEL;
            rx_config_reg <= `ELD_RST_RX_CFG;
            clock_gen_reg <= `ELD_RST_CLOCK_GEN;
            tx_config_reg <= `ELD_RST_TX_CFG;
            reg_rdata_o <= 8'h00;
        end else begin
            loss_cfg_reg <= next_loss_cfg_reg;
            irq_mask_reg <= next_irq_mask_reg;
            irq_edge_select_reg <= next_irq_edge_select_reg;
            rx_config_reg <= next_rx_config_reg;
            clock_gen_reg <= next_clock_gen_reg;
            tx_config_reg <= next_tx_config_reg;
            reg_rdata_o <= next_reg_rdata;
        end
    end

    // ==========================================================
    // line and system detectors
    eld_pkg::eld_tx_mode_e tx_mode;
    eld_pkg::eld_rx_mode_e rx_mode;
    eld_det_if line_det ();
    eld_det_if sys_det ();

    assign tx_mode = eld_pkg::eld_tx_mode_e'(tx_config_reg[`ELD_FLD_MODE_HI:`ELD_FLD_MODE_LO]);
    assign rx_mode = eld_pkg::eld_rx_mode_e'(rx_config_reg[`ELD_FLD_MODE_HI:`ELD_FLD_MODE_LO]);
    assign line_det.enable = 1'b1;
    assign line_det.criteria = loss_cfg_reg[`ELD_BIT_CRITERIA];
    assign line_det.bit_en = line_bit_en_i;
    assign line_det.mark = line_mark_i;
    assign line_det.amp_ok = line_above_clear_i;
    assign sys_det.enable = (tx_mode == eld_pkg::ELD_TX_DR_NRZ) ||
                            (tx_mode == eld_pkg::ELD_TX_DR_RZ);
    assign sys_det.criteria = loss_cfg_reg[`ELD_BIT_CRITERIA];
    assign sys_det.bit_en = sys_bit_en_i;
    assign sys_det.mark = sys_mark_i;
    assign sys_det.amp_ok = 1'b1;

    eld_loss_det u_line_det (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .det(line_det)
    );

    eld_loss_det u_sys_det (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .det(sys_det)
    );

    // ==========================================================
    // transmit line detector
    logic tx_loss, next_tx_loss;
    logic [11:0] tx_cnt, next_tx_cnt;

    always_comb begin
        next_tx_loss = tx_loss;
        next_tx_cnt = tx_cnt;
        if (tx_pulse_ok_i) begin
            next_tx_loss = 1'b0;
            next_tx_cnt = 12'h000;
        end else if (tx_bit_en_i && !tx_loss) begin
            if (tx_cnt >= tx_period_lim(loss_cfg_reg[`ELD_FLD_TX_PER_HI:`ELD_FLD_TX_PER_LO])) begin
                next_tx_loss = 1'b1;
                next_tx_cnt = 12'h000;
            end else begin
                next_tx_cnt = tx_cnt + 12'h001;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_loss <= 1'b0;
            tx_cnt <= 12'h000;
        end else begin
            tx_loss <= next_tx_loss;
            tx_cnt <= next_tx_cnt;
        end
    end

    // ==========================================================
    // status and interrupt bits
    logic [2:0] loss_now;
    logic [2:0] edge_any;
    logic [2:0] irq_set;

    assign loss_now = {tx_loss, sys_det.loss, line_det.loss};

    always_comb begin
        edge_any = {irq_edge_select_reg[`ELD_BIT_TX_EDGE],
                    irq_edge_select_reg[`ELD_BIT_LS_EDGE],
                    irq_edge_select_reg[`ELD_BIT_LS_EDGE]};
        irq_set = (loss_now & ~loss_status_reg) |
                  (edge_any & ~loss_now & loss_status_reg);
        next_irq_status_reg = irq_status_reg;
        if (reg_wr_i && reg_addr_i == `ELD_ADDR_IRQ_STATUS) begin
            next_irq_status_reg = irq_status_reg & ~reg_wdata_i[2:0];
        end
        next_irq_status_reg = next_irq_status_reg | irq_set;
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            loss_status_reg <= 3'h0;
            irq_status_reg <= 3'h0;
        end else begin
            loss_status_reg <= loss_now;
            irq_status_reg <= next_irq_status_reg;
        end
    end

    // ==========================================================
    // reference clock, indication clock and serial scan
    logic [5:0] ref_cnt, next_ref_cnt;
    logic ref_level, next_ref_level;
    logic ind_level, next_ind_level;
    logic ind_rise;
    logic [4:0] slot, next_slot;
    logic serial_bit, next_serial_bit;
    logic marker_bit, next_marker_bit;
    logic [NUM_CH-1:0] scan_vec;

    assign scan_vec = {other_line_loss_i, line_det.loss};

    always_comb begin
        next_ref_cnt = ref_cnt + 6'h01;
        next_ref_level = ref_level;
        if (ref_cnt == REF_LIM) begin
            next_ref_cnt = 6'h00;
            next_ref_level = ~ref_level;
        end
        next_ind_level = clock_gen_reg[`ELD_BIT_IND_CLK_EN] &
                         (next_ref_level ^ clock_gen_reg[`ELD_BIT_IND_CLK_INV]);
        ind_rise = next_ind_level & ~ind_level;
        next_slot = slot;
        next_serial_bit = serial_bit;
        next_marker_bit = marker_bit;
        if (ind_rise) begin
            next_serial_bit = scan_vec[slot];
            next_marker_bit = (slot == 5'h00);
            next_slot = (slot == SLOT_LIM) ? 5'h00 : slot + 5'h01;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ref_cnt <= 6'h00;
            ref_level <= 1'b0;
            ind_level <= 1'b0;
            slot <= 5'h00;
            serial_bit <= 1'b0;
            marker_bit <= 1'b0;
        end else begin
            ref_cnt <= next_ref_cnt;
            ref_level <= next_ref_level;
            ind_level <= next_ind_level;
            slot <= next_slot;
            serial_bit <= next_serial_bit;
            marker_bit <= next_marker_bit;
        end
    end

    // ==========================================================
    // receive output forcing and registered outputs
    logic next_rx_data, next_rx_pos, next_rx_neg, next_rx_clock;
    logic next_irq_b;

    always_comb begin
        next_rx_data = rx_data_i;
        next_rx_pos = rx_data_pos_i;
        next_rx_neg = rx_data_neg_i;
        next_rx_clock = rx_clock_i;
        if (line_det.loss && !rx_override_i) begin
            if (rx_mode != eld_pkg::ELD_RX_DR_SLICED) begin
                next_rx_data = 1'b0;
                next_rx_pos = 1'b0;
                next_rx_neg = 1'b0;
            end
            next_rx_clock = rx_config_reg[`ELD_BIT_RX_CLK_HIGH] ? 1'b1 : ref_level;
        end
        next_irq_b = ~|(next_irq_status_reg & ~irq_mask_reg[2:0]);
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            line_amplitude_threshold_o <= 3'h0;
            tx_amplitude_threshold_o <= 2'h0;
            tx_output_enable_o <= 1'b0;
            line_signal_loss_o <= 1'b0;
            system_signal_loss_o <= 1'b0;
            transmit_signal_loss_o <= 1'b0;
            rx_multiplex_indicator_o <= 1'b0;
            tx_multiplex_indicator_o <= 1'b0;
            irq_b_o <= 1'b1;
            indication_clock_out_o <= 1'b0;
            indication_clock_oe_o <= 1'b0;
            serial_loss_o <= 1'b0;
            serial_loss_oe_o <= 1'b0;
            serial_loss_marker_pin_o <= 1'b0;
            serial_loss_marker_oe_o <= 1'b0;
            rx_data_out_o <= 1'b0;
            rx_data_pos_out_o <= 1'b0;
            rx_data_neg_out_o <= 1'b0;
            rx_clock_out_o <= 1'b0;
        end else begin
            line_amplitude_threshold_o <=
                next_loss_cfg_reg[`ELD_FLD_LINE_THR_HI:`ELD_FLD_LINE_THR_LO];
            tx_amplitude_threshold_o <=
                next_loss_cfg_reg[`ELD_FLD_TX_THR_HI:`ELD_FLD_TX_THR_LO];
            tx_output_enable_o <= next_tx_config_reg[`ELD_BIT_TX_OE];
            line_signal_loss_o <= line_det.loss;
            system_signal_loss_o <= sys_det.loss;
            transmit_signal_loss_o <= tx_loss;
            rx_multiplex_indicator_o <= line_det.loss;
            tx_multiplex_indicator_o <= sys_det.loss | tx_loss;
            irq_b_o <= next_irq_b;
            indication_clock_out_o <= next_ind_level;
            indication_clock_oe_o <= clock_gen_reg[`ELD_BIT_IND_CLK_EN];
            serial_loss_o <= next_serial_bit;
            serial_loss_oe_o <= clock_gen_reg[`ELD_BIT_IND_CLK_EN];
            serial_loss_marker_pin_o <= next_marker_bit;
            serial_loss_marker_oe_o <= clock_gen_reg[`ELD_BIT_IND_CLK_EN];
            rx_data_out_o <= next_rx_data;
            rx_data_pos_out_o <= next_rx_pos;
            rx_data_neg_out_o <= next_rx_neg;
            rx_clock_out_o <= next_rx_clock;
        end
    end
endmodule
`default_nettype wire

//--- tb/eld_top_props.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// loss checker
module eld_chk (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic line_bit_en_i,
    input wire logic sys_bit_en_i,
    input wire logic tx_pulse_ok_i,
    input wire logic line_signal_loss_o,
    input wire logic system_signal_loss_o,
    input wire logic transmit_signal_loss_o,
    input wire logic rx_multiplex_indicator_o,
    input wire logic tx_multiplex_indicator_o,
    input wire logic indication_clock_out_o,
    input wire logic indication_clock_oe_o,
    input wire logic serial_loss_oe_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence tx_gone;
        ##[1:3] !transmit_signal_loss_o;
    endsequence
    rx_mux_a: assert property (rx_multiplex_indicator_o == line_signal_loss_o)
        else $error("rx mux mismatch");
    tx_mux_a: assert property (tx_multiplex_indicator_o ==
        (system_signal_loss_o | transmit_signal_loss_o)) else $error("tx mux mismatch");
    ser_oe_a: assert property (serial_loss_oe_o == indication_clock_oe_o)
        else $error("serial enable mismatch");
    ind_off_a: assert property (!indication_clock_oe_o |-> !indication_clock_out_o)
        else $error("clock runs while off");
    line_decl_a: assert property ($rose(line_signal_loss_o) |->
        $past(line_bit_en_i, 2) || $past(line_bit_en_i, 3)) else $error("line set off bit");
    line_clr_a: assert property ($fell(line_signal_loss_o) |->
        $past(line_bit_en_i, 2) || $past(line_bit_en_i, 3)) else $error("line clr off bit");
    sys_decl_a: assert property ($rose(system_signal_loss_o) |->
        $past(sys_bit_en_i, 2) || $past(sys_bit_en_i, 3)) else $error("sys set off bit");
    tx_clr_a: assert property (transmit_signal_loss_o && tx_pulse_ok_i |-> tx_gone)
        else $error("tx loss not cleared");
endmodule
bind eld_top eld_chk chk_u (.*);
`default_nettype wire

//--- tb/eld_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// line, system and tx far end
module eld_far_end (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [2:0] live_i,
    output logic bit_o,
    output logic [2:0] mark_o
);
    logic [4:0] cnt;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt <= 5'h00;
        end else begin
            cnt <= cnt + 5'h01;
        end
    end
    assign bit_o = (cnt[2:0] == 3'h7);
    assign mark_o = live_i & {3{cnt[4:3] == 2'h0}};
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// testbench
module testbench;
    localparam logic [31:0] ST [33] = '{32'h7000_0307, 32'h7000_11ff, 32'h7000_0100,
        32'h7000_1300, 32'h7000_1580, 32'h60f0_0100, 32'h6028_0101, 32'h6000_0201, 32'h6000_2000,
        32'h6000_1301, 32'h6003_2001, 32'h6000_1300, 32'h6000_1201, 32'h6000_0200,
        32'h7140_0100, 32'h7000_0200, 32'h7000_1402, 32'h6118_0201, 32'h6000_1201,
        32'h7140_0201, 32'h7000_1741, 32'h5118_0102, 32'h5000_1700, 32'h5003_0100,
        32'h3118_0104, 32'h7028_0100, 32'h7000_10fc, 32'h6118_0100, 32'h7000_1000,
        32'h6118_0101, 32'h6000_160c, 32'h6fff_0101, 32'h6fff_0101};
    logic clk = 1'h0, rst_b = 1'h0, wr = 1'h0, rd = 1'h0, ck = 1'h0;
    logic rd_q = 1'h0, ck_q = 1'h0, ind_d = 1'h0, wr_q = 1'h0;
    logic [2:0] addr = 3'h0, live = 3'h7;
    logic [7:0] wd = 8'h00;
    logic [20:0] oth = 21'h000000;
    logic [4:0] rx = 5'h00, rx_q = 5'h00;
    logic [7:0] exp_q [$];
    int seed = 11668, fails = 0, n_checks = 0, cyc = 0, slot = -1;
    wire logic bit_en, lloss, irq_b, ind, mrk, ser, oe;
    wire logic [2:0] mk;
    wire logic [3:0] ro;
    wire logic [4:0] thr;
    wire logic [3:0] rx_exp = (lloss && !rx_q[4]) ? 4'h8 : rx_q[3:0];
    wire logic [7:0] rdata;
    wire logic [21:0] sl = {oth, lloss};
    eld_far_end far_u (.clk_i(clk), .rst_b_i(rst_b), .live_i(live), .bit_o(bit_en), .mark_o(mk));
    eld_top dut_u (.sys_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .line_bit_en_i(bit_en),
        .line_mark_i(mk[0]), .line_above_clear_i(mk[0]), .sys_bit_en_i(bit_en),
        .sys_mark_i(mk[1]), .tx_bit_en_i(bit_en), .tx_pulse_ok_i(mk[2]),
        .other_line_loss_i(oth), .rx_data_i(rx[0]), .rx_data_pos_i(rx[1]),
        .rx_data_neg_i(rx[2]), .rx_clock_i(rx[3]), .rx_override_i(rx[4]),
        .line_amplitude_threshold_o(thr[4:2]), .tx_amplitude_threshold_o(thr[1:0]),
        .tx_output_enable_o(oe),
        .line_signal_loss_o(lloss), .system_signal_loss_o(), .transmit_signal_loss_o(),
        .rx_multiplex_indicator_o(), .tx_multiplex_indicator_o(), .irq_b_o(irq_b),
        .indication_clock_out_o(ind), .indication_clock_oe_o(), .serial_loss_o(ser),
        .serial_loss_oe_o(), .serial_loss_marker_pin_o(mrk), .serial_loss_marker_oe_o(),
        .rx_data_out_o(ro[0]), .rx_data_pos_out_o(ro[1]), .rx_data_neg_out_o(ro[2]),
        .rx_clock_out_o(ro[3]));
    task automatic stop_test();
        if (fails == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        rd_q <= rd;
        ck_q <= ck;
        wr_q <= wr;
        rx_q <= rx;
        rx <= 5'($random(seed));
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fails++;
            stop_test();
        end
    end
    always @(negedge clk) begin
        if (rd_q || ck_q) chk("result", rd_q ? rdata : {7'h00, irq_b}, exp_q.pop_front());
        if (cyc > 20) chk("rx", {4'h0, ro}, {4'h0, rx_exp});
        if (wr_q && addr == 3'h0) chk("thr", {3'h0, thr}, {3'h0, wd[6:2]});
        if (wr_q && addr == 3'h7) chk("oe", {7'h00, oe}, {7'h00, wd[6]});
        ind_d <= ind;
        if (ind && !ind_d) begin
            if (slot >= 0) chk("marker", {7'h00, mrk}, {7'h00, slot == 21});
            slot = mrk ? 0 : (slot < 0 ? -1 : slot + 1);
            if (slot >= 0) chk("serial", {7'h00, ser}, {7'h00, sl[slot]});
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'h1;
        oth <= 21'($random(seed));
        foreach (ST[i]) begin
            live <= ST[i][30:28];
            repeat (ST[i][27:16]) @(posedge clk);
            @(posedge clk);
            addr <= ST[i][10:8];
            wd <= ST[i][7:0];
            wr <= ST[i][12];
            rd <= (ST[i][15:12] == 4'h0);
            ck <= ST[i][13];
            if (!ST[i][12]) exp_q.push_back(ST[i][7:0]);
            @(posedge clk);
            wr <= 1'h0;
            rd <= 1'h0;
            ck <= 1'h0;
        end
        repeat (4) @(posedge clk);
        stop_test();
    end
endmodule
`default_nettype wire
